/* sif_pkg.sv */
// shared constants and carriers for the sync interrupt/monitor register slice
package sif_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets on the host register port
   localparam logic [7:0] ADDR_PLL_A_IRQ_ENABLE = 8'h0A;
   localparam logic [7:0] ADDR_PLL_B_IRQ_ENABLE = 8'h0B;
   localparam logic [7:0] ADDR_REF01_MON_ENABLE = 8'h0C;
   localparam logic [7:0] ADDR_REF23_MON_ENABLE = 8'h0D;
   localparam logic [7:0] ADDR_REF45_MON_ENABLE = 8'h0E;
   localparam logic [7:0] ADDR_REF67_MON_ENABLE = 8'h0F;
   localparam logic [7:0] ADDR_REF01_FREQ_CODE  = 8'h10;
   localparam logic [7:0] ADDR_PLL_A_STATUS     = 8'h18;
   localparam logic [7:0] ADDR_PLL_B_STATUS     = 8'h19;
   localparam logic [7:0] ADDR_REF_IRQ_ENABLE   = 8'h1A;
   localparam logic [7:0] ADDR_REF01_FAIL       = 8'h1C;
   localparam logic [7:0] ADDR_REF67_FAIL       = 8'h1F;

   ////////////////////////////////////////////////////////////////////////////
   // field positions and widths
   localparam int PLL_A_EN_BITS   = 7;  // bits 6:0, bit 7 reserved
   localparam int PLL_B_EN_BITS   = 4;  // bits 3:0, bits 7:4 reserved
   localparam int PLL_A_STAT_BITS = 6;
   localparam int PLL_B_STAT_BITS = 4;
   localparam int BIT_LOCKED      = 0;
   localparam int BIT_LOCK_LOST   = 1;
   localparam int BIT_HOLDOVER    = 2;
   localparam int BIT_REF_SWITCH  = 3;
   localparam int BIT_SYNC_FAIL0  = 4;
   localparam int BIT_SYNC_FAIL1  = 5;
   localparam int MON_FIELD_BITS  = 4;  // scm, cfm, gst, pfm
   localparam int REF_COUNT       = 8;
   localparam int MON_REG_COUNT   = 4;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [6:0] RST_PLL_A_EN   = 7'h00;
   localparam logic [3:0] RST_PLL_B_EN   = 4'h0;
   localparam logic [7:0] RST_MON_ENABLE = 8'hFF;
   localparam logic [7:0] RST_REF_IRQ_EN = 8'h00;
   localparam logic [3:0] FREQ_UNKNOWN   = 4'hF;
   localparam logic [7:0] READ_ZERO      = 8'h00;

   // detected-frequency codes
   localparam logic [3:0] FREQ_2K      = 4'h0;
   localparam logic [3:0] FREQ_77M76   = 4'hA;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic [1:0] sync_fail;   // one per sync input
      logic       ref_switch;
      logic       holdover;
      logic       lock_lost;
      logic       locked;
   } sif_pll_event_type;

   typedef struct packed {
      logic [1:0] valid;       // per reference 1..0
      logic [7:0] code;        // ref1 in 7:4, ref0 in 3:0
   } sif_freq_in_type;

endpackage

/* sif_regs.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sif_regs
   import sif_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   output logic                   irq,
   input  wire sif_pll_event_type pll_a_event,
   input  wire sif_pll_event_type pll_b_event,
   input  wire logic [31:0]       ref_fail_pulse,
   input  wire sif_freq_in_type   ref_freq
);

   /////////////////////////////////////////////////////////////////////////////
   // sticky flag update: the set term wins over any clear
   function automatic logic [7:0] sif_sticky(input logic [7:0] cur,
                                             input logic [7:0] set,
                                             input logic [7:0] clr);
      sif_sticky = (cur & ~clr) | set;
   endfunction

   /////////////////////////////////////////////////////////////////////////////
   // storage
   logic [6:0] pll_a_irq_enable;
   logic [3:0] pll_b_irq_enable;
   logic [7:0] mon_enable [MON_REG_COUNT];
   logic [7:0] ref01_freq_code;
   logic [5:0] pll_a_status;
   logic [3:0] pll_b_status;
   logic [7:0] ref_fail_status [MON_REG_COUNT];
   logic [7:0] ref_irq_enable;

   /////////////////////////////////////////////////////////////////////////////
   // address decode
   wire hit_pll_a_en  = (reg_addr == ADDR_PLL_A_IRQ_ENABLE);
   wire hit_pll_b_en  = (reg_addr == ADDR_PLL_B_IRQ_ENABLE);
   wire hit_mon       = (reg_addr[7:2] == ADDR_REF01_MON_ENABLE[7:2]);
   wire hit_freq      = (reg_addr == ADDR_REF01_FREQ_CODE);
   wire hit_pll_a_st  = (reg_addr == ADDR_PLL_A_STATUS);
   wire hit_pll_b_st  = (reg_addr == ADDR_PLL_B_STATUS);
   wire hit_ref_irq   = (reg_addr == ADDR_REF_IRQ_ENABLE);
   wire hit_fail      = (reg_addr[7:2] == ADDR_REF01_FAIL[7:2]);
   wire [1:0] reg_idx = reg_addr[1:0];

   // write strobes per register, read strobes for the two status registers
   wire wr_pll_a_en   = reg_wr && hit_pll_a_en;
   wire wr_pll_b_en   = reg_wr && hit_pll_b_en;
   wire wr_mon        = reg_wr && hit_mon;
   wire wr_pll_a_st   = reg_wr && hit_pll_a_st;
   wire wr_pll_b_st   = reg_wr && hit_pll_b_st;
   wire wr_ref_irq    = reg_wr && hit_ref_irq;
   wire wr_fail       = reg_wr && hit_fail;
   wire rd_pll_a_st   = reg_rd && hit_pll_a_st;
   wire rd_pll_b_st   = reg_rd && hit_pll_b_st;

   /////////////////////////////////////////////////////////////////////////////
   // channel enable registers; reserved bits are not stored
   // enables reset to zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pll_a_irq_enable <= RST_PLL_A_EN;
         pll_b_irq_enable <= RST_PLL_B_EN;
         ref_irq_enable   <= RST_REF_IRQ_EN;
      end else begin
         if (wr_pll_a_en)
            pll_a_irq_enable <= reg_wdata[PLL_A_EN_BITS-1:0];
         if (wr_pll_b_en)
            pll_b_irq_enable <= reg_wdata[PLL_B_EN_BITS-1:0];
         if (wr_ref_irq)
            ref_irq_enable <= reg_wdata;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // channel status: events set sticky bits, write one clears
   // reading the status also clears the switch flag
   // struct order puts locked at bit 0
   // channel A sync failures land in bits 5:4; channel B drops them
   wire [7:0] pll_a_set = {2'h0, pll_a_event};
   wire [7:0] pll_b_set = {4'h0, pll_b_event[3:0]};
   wire [7:0] rd_clr_sw = 8'h01 << BIT_REF_SWITCH;   // switch flag position
   wire [7:0] pll_a_clr = (wr_pll_a_st ? reg_wdata : READ_ZERO)
                        | (rd_pll_a_st ? rd_clr_sw : READ_ZERO);
   wire [7:0] pll_b_clr = (wr_pll_b_st ? reg_wdata : READ_ZERO)
                        | (rd_pll_b_st ? rd_clr_sw : READ_ZERO);
   wire [7:0] next_pll_a_status = sif_sticky({2'h0, pll_a_status},
                                             pll_a_set, pll_a_clr);
   wire [7:0] next_pll_b_status = sif_sticky({4'h0, pll_b_status},
                                             pll_b_set, pll_b_clr);

   // status flip-flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pll_a_status <= 6'h00;
         pll_b_status <= 4'h0;
      end else begin
         pll_a_status <= next_pll_a_status[PLL_A_STAT_BITS-1:0];
         pll_b_status <= next_pll_b_status[PLL_B_STAT_BITS-1:0];
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // per-pair monitor enables and sticky failure flags
   genvar gi;
   generate
      for (gi = 0; gi < MON_REG_COUNT; gi++) begin : g_mon
         // only enabled indicators reach the flags
         wire [7:0] fail_set = ref_fail_pulse[8*gi +: 8] & mon_enable[gi];
         wire [7:0] fail_clr = (wr_fail && reg_idx == gi) ? reg_wdata
                                                          : READ_ZERO;
         // even ref in low nibble, odd ref in high nibble
         wire       wr_this  = wr_mon && (reg_idx == gi);

         // monitor enables reset to all ones
         always_ff @(posedge core_clk) begin
            if (rst)
               mon_enable[gi] <= RST_MON_ENABLE;
            else if (wr_this)
               mon_enable[gi] <= reg_wdata;
         end

         always_ff @(posedge core_clk) begin
            if (rst)
               ref_fail_status[gi] <= READ_ZERO;
            else
               ref_fail_status[gi] <= sif_sticky(ref_fail_status[gi],
                                                 fail_set, fail_clr);
         end
      end
   endgenerate

   // one summary flag per reference
   wire [REF_COUNT-1:0] ref_any;
   generate
      for (gi = 0; gi < REF_COUNT; gi++) begin : g_any
         assign ref_any[gi] =
            |ref_fail_status[gi/2][MON_FIELD_BITS*(gi%2) +: MON_FIELD_BITS];
      end
   endgenerate

   /////////////////////////////////////////////////////////////////////////////
   // detected frequency codes for references 0 and 1
   // codes pass through as reported by the detector
   // upper code range passes the same way
   // no valid detection reads as all ones
   wire [3:0] next_freq0 = ref_freq.valid[0] ? ref_freq.code[3:0]
                                             : FREQ_UNKNOWN;
   wire [3:0] next_freq1 = ref_freq.valid[1] ? ref_freq.code[7:4]
                                             : FREQ_UNKNOWN;

   // ref0 low nibble, ref1 high nibble
   always_ff @(posedge core_clk) begin
      if (rst)
         ref01_freq_code <= {FREQ_UNKNOWN, FREQ_UNKNOWN};
      else
         ref01_freq_code <= {next_freq1, next_freq0};
   end

   /////////////////////////////////////////////////////////////////////////////
   // interrupt: any set flag whose enable is one
   // channel A enable gates its flags
   wire irq_a   = |(pll_a_status & pll_a_irq_enable[PLL_A_STAT_BITS-1:0]);
   // channel B enable gates its flags
   wire irq_b   = |(pll_b_status & pll_b_irq_enable);
   wire irq_ref = |(ref_any & ref_irq_enable);
   // level output from any enabled source
   wire next_irq = irq_a || irq_b || irq_ref;

   always_ff @(posedge core_clk) begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= next_irq;
   end

   /////////////////////////////////////////////////////////////////////////////
   // read mux; reserved bits and unmapped addresses read zero
   // bit 7 of channel A reads as its default
   wire [7:0] rd_pll_a_en = {1'b0, pll_a_irq_enable};
   wire [7:0] rd_pll_b_en = {4'h0, pll_b_irq_enable};
   wire [7:0] next_rdata =
      hit_pll_a_en ? rd_pll_a_en :
      hit_pll_b_en ? rd_pll_b_en :
      hit_mon      ? mon_enable[reg_idx] :
      hit_freq     ? ref01_freq_code :
      hit_pll_a_st ? {2'h0, pll_a_status} :
      hit_pll_b_st ? {4'h0, pll_b_status} :
      hit_ref_irq  ? ref_irq_enable :
      hit_fail     ? ref_fail_status[reg_idx] :
                     READ_ZERO;

   // read data valid in the cycle after the strobe only
   always_ff @(posedge core_clk) begin
      if (rst)
         reg_rdata <= READ_ZERO;
      else if (reg_rd)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= READ_ZERO;
   end

   /////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_pll_a_reserved: assert property (
      reg_rd && hit_pll_a_en |=> reg_rdata[7] == 1'b0)
      else $error("channel A reserved bit read nonzero");

   a_pll_b_reserved: assert property (
      reg_rd && hit_pll_b_en |=> reg_rdata[7:4] == 4'h0)
      else $error("channel B reserved bits read nonzero");

   a_pll_a_write_read: assert property (
      reg_wr && hit_pll_a_en ##1 reg_rd && hit_pll_a_en
      |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 2))
      else $error("channel A enable did not hold written value");

   a_irq_locked: assert property (
      pll_a_event.locked && pll_a_irq_enable[BIT_LOCKED]
      && !(reg_wr && hit_pll_a_en) |=> ##1 irq)
      else $error("enabled locked event gave no interrupt");

   a_irq_quiet: assert property (
      pll_a_irq_enable == 7'h00 && pll_b_irq_enable == 4'h0
      && ref_irq_enable == 8'h00 |=> !irq)
      else $error("interrupt with every enable clear");

   a_reset_values: assert property (
      $fell(rst) |-> pll_a_irq_enable == 7'h00
      && pll_b_irq_enable == 4'h0 && mon_enable[0] == 8'hFF
      && mon_enable[3] == 8'hFF)
      else $error("enable registers wrong after reset");

   a_freq_unknown: assert property (
      !ref_freq.valid[0] |=> ref01_freq_code[3:0] == 4'hF)
      else $error("unknown frequency not all ones");

   a_freq_capture: assert property (
      ref_freq.valid[1] |=> ref01_freq_code[7:4] == $past(ref_freq.code[7:4]))
      else $error("ref1 code not in high nibble");

   a_mon_gate: assert property (
      ref_fail_pulse[0] && !mon_enable[0][0] && !ref_fail_status[0][0]
      |=> !ref_fail_status[0][0])
      else $error("masked indicator set a failure flag");

   a_fail_sticky: assert property (
      ref_fail_status[0][5] && !(wr_fail && reg_idx == 2'h0 && reg_wdata[5])
      |=> ref_fail_status[0][5])
      else $error("enabled failure flag did not stick");

   a_switch_rd_clear: assert property (
      rd_pll_a_st && !pll_a_event.ref_switch |=> !pll_a_status[BIT_REF_SWITCH])
      else $error("switch flag survived status read");

   a_pll_a_write: assert property (
      reg_wr && hit_pll_a_en
      |=> pll_a_irq_enable == $past(reg_wdata[PLL_A_EN_BITS-1:0]))
      else $error("channel A enable write not stored");

   a_pll_b_write: assert property (
      reg_wr && hit_pll_b_en
      |=> pll_b_irq_enable == $past(reg_wdata[PLL_B_EN_BITS-1:0]))
      else $error("channel B enable write not stored");

   a_mon_write: assert property (
      wr_mon && reg_idx == 2'h1 |=> mon_enable[1] == $past(reg_wdata))
      else $error("monitor enable write landed in wrong register");

   a_irq_b_locked: assert property (
      pll_b_status[BIT_LOCKED] && pll_b_irq_enable[BIT_LOCKED] |=> irq)
      else $error("enabled channel B flag gave no interrupt");

   a_sync_gate: assert property (
      pll_a_status[BIT_SYNC_FAIL0] && pll_a_irq_enable[BIT_SYNC_FAIL0]
      |=> irq)
      else $error("enabled sync failure gave no interrupt");

   a_ref_irq: assert property (
      ref_any[0] && ref_irq_enable[0] |=> irq)
      else $error("enabled reference failure gave no interrupt");

   a_status_clear: assert property (
      wr_pll_a_st && reg_wdata[BIT_LOCKED] && !pll_a_event.locked
      |=> !pll_a_status[BIT_LOCKED])
      else $error("write one did not clear channel A flag");

   a_switch_keep: assert property (
      pll_a_status[BIT_REF_SWITCH] && !rd_pll_a_st && !wr_pll_a_st
      |=> pll_a_status[BIT_REF_SWITCH])
      else $error("switch flag lost without read or clear");

   a_switch_b_clear: assert property (
      rd_pll_b_st && !pll_b_event.ref_switch
      |=> !pll_b_status[BIT_REF_SWITCH])
      else $error("channel B switch flag survived status read");

   a_fail_set: assert property (
      ref_fail_pulse[5] && mon_enable[0][5] |=> ref_fail_status[0][5])
      else $error("enabled indicator did not set its flag");

   a_mon_gate_b: assert property (
      ref_fail_pulse[4] && !mon_enable[0][4] && !ref_fail_status[0][4]
      |=> !ref_fail_status[0][4])
      else $error("masked ref1 indicator set a failure flag");

   a_fail_clear: assert property (
      wr_fail && reg_idx == 2'h0 && reg_wdata[0] && !ref_fail_pulse[0]
      |=> !ref_fail_status[0][0])
      else $error("write one did not clear failure flag");

   a_set_wins: assert property (
      wr_fail && reg_idx == 2'h0 && ref_fail_pulse[0] && mon_enable[0][0]
      |=> ref_fail_status[0][0])
      else $error("clear beat a failure in the same cycle");

   a_freq_low: assert property (
      ref_freq.valid[0] |=> ref01_freq_code[3:0] == $past(ref_freq.code[3:0]))
      else $error("ref0 code not in low nibble");

   a_freq_high_unknown: assert property (
      !ref_freq.valid[1] |=> ref01_freq_code[7:4] == FREQ_UNKNOWN)
      else $error("unknown ref1 frequency not all ones");

   a_freq_bottom: assert property (
      ref_freq.valid[0] && ref_freq.code[3:0] == FREQ_2K
      |=> ref01_freq_code[3:0] == FREQ_2K)
      else $error("lowest frequency code not reported");

   a_freq_top: assert property (
      ref_freq.valid[1] && ref_freq.code[7:4] == FREQ_77M76
      |=> ref01_freq_code[7:4] == FREQ_77M76)
      else $error("highest frequency code not reported");

   a_freq_read: assert property (
      reg_rd && hit_freq |=> reg_rdata == $past(ref01_freq_code))
      else $error("frequency register read wrong data");

   a_freq_read_only: assert property (
      reg_wr && hit_freq && ref_freq.valid == 2'h0
      |=> ref01_freq_code == 8'hFF)
      else $error("write changed the frequency register");

   c_irq_raised: cover property (!irq ##1 irq);
   c_switch_cleared: cover property (
      pll_a_status[BIT_REF_SWITCH] && rd_pll_a_st);
   c_set_beats_clear: cover property (
      wr_fail && ref_fail_pulse[0] && mon_enable[0][0]);
   c_freq_known: cover property (ref_freq.valid == 2'h3);
   c_fail_held: cover property (ref_fail_status[0][5] ##1 ref_fail_status[0][5]);

endmodule

/* sif_regs_test.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sif_regs_test
   import sif_pkg::*;
;
   logic              core_clk;
   logic              rst;
   logic [7:0]        reg_addr;
   logic [7:0]        reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [7:0]        reg_rdata;
   logic              irq;
   sif_pll_event_type pll_a_event;
   sif_pll_event_type pll_b_event;
   logic [31:0]       ref_fail_pulse;
   sif_freq_in_type   ref_freq;
   int                n_errors;
   int                checked;

   sif_regs i_dut (
      .core_clk       (core_clk),
      .rst            (rst),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_rdata      (reg_rdata),
      .irq            (irq),
      .pll_a_event    (pll_a_event),
      .pll_b_event    (pll_b_event),
      .ref_fail_pulse (ref_fail_pulse),
      .ref_freq       (ref_freq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;

   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   // write then read back with no idle cycle between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                        input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge core_clk);
      reg_rd    <= 1'b0;
      @(negedge core_clk);
      check(reg_rdata, exp);
   endtask

   // one-cycle read strobe, data checked in the following cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(negedge core_clk);
      check(reg_rdata, exp);
   endtask

   // one-cycle event pulse, then wait until irq has had time to follow
   task automatic pulse(input int which, input logic [31:0] v);
      @(posedge core_clk);
      case (which)
         0: pll_a_event <= sif_pll_event_type'(v[5:0]);
         1: pll_b_event <= sif_pll_event_type'(v[5:0]);
         default: ref_fail_pulse <= v;
      endcase
      @(posedge core_clk);
      pll_a_event    <= '0;
      pll_b_event    <= '0;
      ref_fail_pulse <= 32'h0000_0000;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   // verdict and end of run
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog against a hung run
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      summarize();
   end

   // main sequence
   initial begin
      logic [7:0] ea;
      logic [7:0] sa;
      logic [7:0] full;
      logic [7:0] bit_v;
      logic [3:0] cc;
      int         nb;
      core_clk       = 1'b0;
      rst            = 1'b1;
      reg_addr       = 8'h00;
      reg_wdata      = 8'h00;
      reg_wr         = 1'b0;
      reg_rd         = 1'b0;
      pll_a_event    = '0;
      pll_b_event    = '0;
      ref_fail_pulse = 32'h0000_0000;
      ref_freq       = '0;
      n_errors       = 0;
      checked        = 0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      // reset values and access kinds
      rd(8'h0A, 8'h00);
      rd(8'h0B, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rd(8'h0C + 8'(i), 8'hFF);
      end
      rd(8'h10, 8'hFF);
      wr_rd(8'h0A, 8'hFF, 8'h7F);
      wr(8'h0B, 8'hFF);
      rd(8'h0B, 8'h0F);
      wr(8'h0D, 8'h5A);
      rd(8'h0D, 8'h5A);
      wr(8'h0D, 8'hFF);
      wr(8'h10, 8'h00);
      rd(8'h10, 8'hFF);
      wr(8'h30, 8'h55);
      rd(8'h30, 8'h00);
      $display("test reset and access done");
      // every frequency code on both nibbles
      for (int c = 0; c <= 10; c++) begin
         cc = 4'(c);
         @(posedge core_clk);
         ref_freq <= sif_freq_in_type'({2'b11, cc, 4'hA - cc});
         rd(8'h10, {cc, 4'hA - cc});
      end
      @(posedge core_clk);
      ref_freq <= sif_freq_in_type'({2'b01, 4'h3, 4'h5});
      rd(8'h10, 8'hF5);
      @(posedge core_clk);
      ref_freq <= sif_freq_in_type'({2'b10, 4'h3, 4'h5});
      rd(8'h10, 8'h3F);
      $display("test frequency codes done");
      // per-event interrupt enables on both channels
      for (int ch = 0; ch < 2; ch++) begin
         ea   = (ch == 0) ? 8'h0A : 8'h0B;
         sa   = (ch == 0) ? 8'h18 : 8'h19;
         full = (ch == 0) ? 8'h7F : 8'h0F;
         nb   = (ch == 0) ? 6 : 4;
         for (int b = 0; b < nb; b++) begin
            bit_v = 8'h01 << b;
            wr(ea, full ^ bit_v);
            pulse(ch, {24'h00_0000, bit_v});
            check({7'h00, irq}, 8'h00);
            wr(ea, bit_v);
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            check({7'h00, irq}, 8'h01);
            rd(sa, bit_v);
            if (b != 3) begin
               wr(sa, bit_v);
            end
            rd(sa, 8'h00);
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            check({7'h00, irq}, 8'h00);
         end
         wr(ea, full);
         pulse(ch, 32'h0000_0001);
         check({7'h00, irq}, 8'h01);
         wr(sa, 8'h01);
         wr(ea, 8'h00);
      end
      $display("test channel interrupts done");
      // monitor enables gate each ref0/ref1 failure indicator and the top ref7 one
      for (int i = 0; i < 8; i++) begin
         bit_v = 8'h01 << i;
         wr(8'h1A, (i < 4) ? 8'h01 : 8'h02);
         wr(8'h0C, 8'hFF ^ bit_v);
         pulse(2, {24'h00_0000, bit_v});
         rd(8'h1C, 8'h00);
         check({7'h00, irq}, 8'h00);
         wr(8'h0C, 8'hFF);
         pulse(2, {24'h00_0000, bit_v});
         rd(8'h1C, bit_v);
         rd(8'h1C, bit_v);
         check({7'h00, irq}, 8'h01);
         wr(8'h1C, bit_v);
         rd(8'h1C, 8'h00);
         check({7'h00, irq}, 8'h00);
      end
      wr(8'h0F, 8'h7F);
      pulse(2, 32'h8000_0000);
      rd(8'h1F, 8'h00);
      wr(8'h0F, 8'hFF);
      pulse(2, 32'h8000_0000);
      rd(8'h1F, 8'h80);
      wr(8'h1F, 8'h80);
      $display("test monitor enables done");
      summarize();
   end

endmodule
